// [logic/cmt_pkg.sv]
package cmt_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PRESCALE = 8'hA1;
  localparam logic [7:0] IDX_MAILBOX  = 8'hA3;
  localparam logic [7:0] IDX_TTC_LO   = 8'hA4;
  localparam logic [7:0] IDX_TTC_HI   = 8'hA5;
  localparam logic [7:0] IDX_TIM_LO   = 8'hAC;
  localparam logic [7:0] IDX_TIM_HI   = 8'hAD;
  localparam logic [7:0] IDX_STMP_LO  = 8'hAE;
  localparam logic [7:0] IDX_STMP_HI  = 8'hAF;
  localparam logic [7:0] IDX_PAGE     = 8'hB1;
  localparam logic [7:0] IDX_MASK1    = 8'hC4;
  localparam logic [7:0] IDX_MASK2    = 8'hC5;
  localparam logic [7:0] IDX_MASK3    = 8'hC6;
  localparam logic [7:0] IDX_MASK4    = 8'hC7;
  localparam int         ADDR_IDX_LSB = 2;
  localparam int         ADDR_IDX_MSB = 9;

  // ==========================================================
  // Field positions
  localparam int PAGE_MOB_LSB  = 4;
  localparam int PAGE_AINC_BIT = 3;
  localparam int MASK4_ID_LSB  = 3;
  localparam int MASK4_RTR_BIT = 2;
  localparam int MASK4_RSV_BIT = 1;
  localparam int MASK4_IDE_BIT = 0;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0]  PRESCALE_RST = 8'h00;
  localparam logic [15:0] TIMER_RST    = 16'h0000;
  localparam logic [7:0]  PAGE_RST     = 8'h00;
  localparam logic [28:0] MASK_RST     = 29'h00000000;
  localparam int          MOB_BYTES    = 8;
  localparam int          NUM_MOB_DEF  = 15;
  localparam int          NUM_MOB_MAX  = 16;

  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_DATA = 2'b01,
    BS_RESP = 2'b10
  } cmt_bus_state_t;

  typedef struct packed {
    logic [28:0] id;
    logic        rtr;
    logic        ide;
  } cmt_ident_t;

  typedef struct packed {
    logic       valid;
    logic       isTx;
    cmt_ident_t rx;
    cmt_ident_t tag;
  } cmt_cmp_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } cmt_ahb_req_t;

  typedef struct packed {
    cmt_bus_state_t bst;
    logic           bWrite;
    logic           bMapped;
    logic [7:0]     bIdx;
    logic [7:0]     rdata;
    logic [7:0]     prescale;
    logic [7:0]     preCnt;
    logic [15:0]    timer;
    logic [15:0]    stamp;
    logic [15:0]    ttc;
    cmt_ident_t     mask;
    logic [3:0]     pageMob;
    logic           autoInc;
    logic [2:0]     byteIdx;
    logic           hit;
  } cmt_state_t;

endpackage

// [logic/cmt_regs.sv]
// Functional notes
// [RQ1] A clear identifier mask bit forces that bit to match; a set bit compares it to the tag.
// [RQ2] A clear remote-request mask bit forces a match; a set one compares the flag to its tag.
// [RQ3] A clear extension mask bit forces a match; a set one compares the extension flag.
// [RQ4] The mask acts only on received frames; transmit comparisons use every bit.
// [RQ5] Mask byte four holds id mask 4..0 in bits 7-3, remote mask bit 2, extension bit 0, bit 1 unused.
// [RQ6] The mailbox window shows the byte at the selected message object plus the byte index.
// [RQ7] With auto-increment on, the byte index steps by one after each window read or write.
// [RQ8] The byte index counts 0 to 7 and wraps to 0.
// [RQ9] An eight-bit prescaler, reset to zero, divides the clock of the timer.
// [RQ10] The message timer is 16 bits read as two bytes; its high byte resets to zero.
// [RQ11] The time stamp is read-only as two bytes.
// [RQ12] The trigger timer value is read-only as two bytes.
// [RQ13] The timer steps once per prescale plus one clocks; the stamp takes the timer at frame events.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module cmt_regs #(
  parameter int NUM_MOB = cmt_pkg::NUM_MOB_DEF
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire cmt_pkg::cmt_ahb_req_t ahbReq,
  input  wire logic [31:0]          hwdata,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire cmt_pkg::cmt_cmp_t    cmpIn,
  output logic                      acceptHit,
  input  wire logic                 frameEvent,
  input  wire logic                 ttcEvent,
  output logic [15:0]               timerValue
);

  localparam int MEM_AW = 7;

  if (NUM_MOB < 1 || NUM_MOB > cmt_pkg::NUM_MOB_MAX) begin : g_num_mob_check
    $error("NUM_MOB out of range");
  end

  // ==========================================================
  // Decode and compare helpers
  function automatic logic isMapped(input logic [7:0] idx);
    case (idx)
      cmt_pkg::IDX_PRESCALE, cmt_pkg::IDX_MAILBOX, cmt_pkg::IDX_TTC_LO,
      cmt_pkg::IDX_TTC_HI, cmt_pkg::IDX_TIM_LO, cmt_pkg::IDX_TIM_HI,
      cmt_pkg::IDX_STMP_LO, cmt_pkg::IDX_STMP_HI, cmt_pkg::IDX_PAGE,
      cmt_pkg::IDX_MASK1, cmt_pkg::IDX_MASK2, cmt_pkg::IDX_MASK3,
      cmt_pkg::IDX_MASK4: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic identMatch(input cmt_pkg::cmt_ident_t a,
                                      input cmt_pkg::cmt_ident_t b,
                                      input cmt_pkg::cmt_ident_t m);
    identMatch = (((a.id ^ b.id) & m.id) == 29'h00000000)         // RQ1
               && !((a.rtr ^ b.rtr) && m.rtr)                     // RQ2
               && !((a.ide ^ b.ide) && m.ide);                    // RQ3
  endfunction

  // ==========================================================
  // State
  cmt_pkg::cmt_state_t s_reg;
  cmt_pkg::cmt_state_t s_next;
  logic [7:0]          mbox [NUM_MOB*cmt_pkg::MOB_BYTES];
  logic [MEM_AW-1:0]   memAddr;
  logic                memSel;
  logic                memWe;
  logic                addrTake;
  logic                preTick;
  logic                winDone;
  logic                regWr;
  logic [7:0]          wByte;
  logic [7:0]          rByte;
  cmt_pkg::cmt_ident_t effMask;

  assign memAddr  = {s_reg.pageMob, s_reg.byteIdx};                   // RQ6
  assign memSel   = 32'(s_reg.pageMob) < NUM_MOB;
  assign winDone  = s_reg.bst == cmt_pkg::BS_DATA && s_reg.bMapped
                 && s_reg.bIdx == cmt_pkg::IDX_MAILBOX;
  assign regWr    = s_reg.bst == cmt_pkg::BS_DATA && s_reg.bWrite && s_reg.bMapped;
  assign memWe    = winDone && s_reg.bWrite && memSel;
  assign addrTake = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
  assign preTick  = s_reg.preCnt == s_reg.prescale;                   // RQ9
  assign wByte    = hwdata[7:0];

  always_comb begin
    case (s_reg.bIdx)
      cmt_pkg::IDX_PRESCALE: rByte = s_reg.prescale;
      cmt_pkg::IDX_MAILBOX:  rByte = memSel ? mbox[memAddr] : 8'h00;  // RQ6
      cmt_pkg::IDX_TTC_LO:   rByte = s_reg.ttc[7:0];                  // RQ12
      cmt_pkg::IDX_TTC_HI:   rByte = s_reg.ttc[15:8];                 // RQ12
      cmt_pkg::IDX_TIM_LO:   rByte = s_reg.timer[7:0];                // RQ10
      cmt_pkg::IDX_TIM_HI:   rByte = s_reg.timer[15:8];               // RQ10
      cmt_pkg::IDX_STMP_LO:  rByte = s_reg.stamp[7:0];                // RQ11
      cmt_pkg::IDX_STMP_HI:  rByte = s_reg.stamp[15:8];               // RQ11
      cmt_pkg::IDX_PAGE:     rByte = {s_reg.pageMob, s_reg.autoInc, s_reg.byteIdx};
      cmt_pkg::IDX_MASK1:    rByte = s_reg.mask.id[28:21];
      cmt_pkg::IDX_MASK2:    rByte = s_reg.mask.id[20:13];
      cmt_pkg::IDX_MASK3:    rByte = s_reg.mask.id[12:5];
      cmt_pkg::IDX_MASK4:    rByte = {s_reg.mask.id[4:0], s_reg.mask.rtr,
                                      1'b0, s_reg.mask.ide};          // RQ5
      default:               rByte = 8'h00;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    // Transmit comparisons ignore the mask
    effMask = cmpIn.isTx ? '1 : s_reg.mask;                           // RQ4
    s_next.hit = cmpIn.valid && identMatch(cmpIn.rx, cmpIn.tag, effMask);
    s_next.preCnt = preTick ? 8'h00 : s_reg.preCnt + 8'h01;           // RQ9
    if (preTick) begin
      s_next.timer = s_reg.timer + 16'h0001;                          // RQ13
    end
    if (frameEvent) begin
      s_next.stamp = s_reg.timer;                                     // RQ13
    end
    if (ttcEvent) begin
      s_next.ttc = s_reg.timer;
    end
    case (s_reg.bst)
      cmt_pkg::BS_IDLE, cmt_pkg::BS_RESP: begin
        if (addrTake) begin
          s_next.bst     = cmt_pkg::BS_DATA;
          s_next.bWrite  = ahbReq.hwrite;
          s_next.bIdx    = ahbReq.haddr[cmt_pkg::ADDR_IDX_MSB:cmt_pkg::ADDR_IDX_LSB];
          s_next.bMapped = ahbReq.haddr[31:10] == 22'h000000
                        && isMapped(ahbReq.haddr[cmt_pkg::ADDR_IDX_MSB:cmt_pkg::ADDR_IDX_LSB]);
        end else begin
          s_next.bst = cmt_pkg::BS_IDLE;
        end
      end
      cmt_pkg::BS_DATA: begin
        s_next.bst   = cmt_pkg::BS_RESP;
        s_next.rdata = (s_reg.bWrite || !s_reg.bMapped) ? 8'h00 : rByte;
        if (s_reg.bWrite && s_reg.bMapped) begin
          case (s_reg.bIdx)
            cmt_pkg::IDX_PRESCALE: s_next.prescale = wByte;
            cmt_pkg::IDX_TIM_LO:   s_next.timer[7:0] = wByte;
            cmt_pkg::IDX_TIM_HI:   s_next.timer[15:8] = wByte;
            cmt_pkg::IDX_PAGE: begin
              s_next.pageMob = wByte[7:cmt_pkg::PAGE_MOB_LSB];
              s_next.autoInc = wByte[cmt_pkg::PAGE_AINC_BIT];
              s_next.byteIdx = wByte[2:0];
            end
            cmt_pkg::IDX_MASK1: s_next.mask.id[28:21] = wByte;
            cmt_pkg::IDX_MASK2: s_next.mask.id[20:13] = wByte;
            cmt_pkg::IDX_MASK3: s_next.mask.id[12:5] = wByte;
            cmt_pkg::IDX_MASK4: begin
              s_next.mask.id[4:0] = wByte[7:cmt_pkg::MASK4_ID_LSB];   // RQ5
              s_next.mask.rtr = wByte[cmt_pkg::MASK4_RTR_BIT];
              s_next.mask.ide = wByte[cmt_pkg::MASK4_IDE_BIT];
            end
            default: ;
          endcase
        end
        if (winDone && s_reg.autoInc) begin
          s_next.byteIdx = s_reg.byteIdx + 3'd1;                      // RQ7 RQ8
        end
      end
      default: s_next.bst = cmt_pkg::BS_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.bst      <= cmt_pkg::BS_IDLE;
      s_reg.prescale <= cmt_pkg::PRESCALE_RST;                        // RQ9
      s_reg.timer    <= cmt_pkg::TIMER_RST;                           // RQ10
      s_reg.mask.id  <= cmt_pkg::MASK_RST;
      {s_reg.pageMob, s_reg.autoInc, s_reg.byteIdx} <= cmt_pkg::PAGE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (memWe) begin
      mbox[memAddr] <= wByte;                                         // RQ6
    end
  end

  assign hrdata     = {24'h000000, s_reg.rdata};
  assign hreadyout  = s_reg.bst != cmt_pkg::BS_DATA;
  assign hresp      = 1'b0;
  assign acceptHit  = s_reg.hit;
  assign timerValue = s_reg.timer;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_mask_forced_pass: assert property ( // RQ1
    (cmpIn.valid && !cmpIn.isTx && s_reg.mask.id == 29'h00000000
     && !s_reg.mask.rtr && !s_reg.mask.ide) |=> acceptHit)
    else $error("cleared mask did not force a match");

  chk_rtr_mask_compare: assert property ( // RQ2
    (cmpIn.valid && !cmpIn.isTx && s_reg.mask.rtr
     && cmpIn.rx.rtr != cmpIn.tag.rtr) |=> !acceptHit)
    else $error("remote flag mismatch accepted");

  chk_ide_mask_compare: assert property ( // RQ3
    (cmpIn.valid && !cmpIn.isTx && s_reg.mask.ide
     && cmpIn.rx.ide != cmpIn.tag.ide) |=> !acceptHit)
    else $error("extension flag mismatch accepted");

  chk_tx_full_compare: assert property ( // RQ4
    (cmpIn.valid && cmpIn.isTx) |=> acceptHit == ($past(cmpIn.rx) == $past(cmpIn.tag)))
    else $error("mask influenced a transmit compare");

  chk_mask4_reserved: assert property ( // RQ5
    (s_reg.bst == cmt_pkg::BS_DATA && !s_reg.bWrite && s_reg.bMapped
     && s_reg.bIdx == cmt_pkg::IDX_MASK4) |=> hrdata[cmt_pkg::MASK4_RSV_BIT] == 1'b0)
    else $error("reserved mask bit read as one");

  chk_window_step: assert property ( // RQ7
    (winDone && s_reg.autoInc) |=> s_reg.byteIdx == $past(s_reg.byteIdx) + 3'd1)
    else $error("byte index did not step");

  chk_window_wrap: assert property ( // RQ8
    (winDone && s_reg.autoInc && s_reg.byteIdx == 3'd7) |=> s_reg.byteIdx == 3'd0)
    else $error("byte index did not wrap");

  chk_window_hold: assert property ( // RQ7
    (winDone && !s_reg.autoInc) |=> $stable(s_reg.byteIdx))
    else $error("byte index moved with auto-increment off");

  chk_timer_step: assert property ( // RQ13
    (!rst && preTick && !(s_reg.bst == cmt_pkg::BS_DATA && s_reg.bWrite))
    |=> timerValue == $past(timerValue) + 16'h0001)
    else $error("timer missed a prescaler tick");

  chk_prescale_gap: assert property ( // RQ9
    (!preTick && !(s_reg.bst == cmt_pkg::BS_DATA && s_reg.bWrite)) |=> $stable(timerValue))
    else $error("timer moved between ticks");

  chk_stamp_capture: assert property ( // RQ11
    frameEvent |=> s_reg.stamp == $past(timerValue))
    else $error("stamp missed the frame event");

  chk_ttc_readonly: assert property ( // RQ12
    !ttcEvent |=> $stable(s_reg.ttc))
    else $error("trigger timer changed without an event");

  chk_bus_wait: assert property (
    (addrTake) |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not one wait state");

  chk_refused_read: assert property (
    (s_reg.bst == cmt_pkg::BS_DATA && !s_reg.bWrite && !s_reg.bMapped)
    |=> hrdata == 32'h00000000)
    else $error("refused read returned data");

  chk_window_refused: assert property ( // RQ7
    (s_reg.bst == cmt_pkg::BS_DATA && !s_reg.bMapped && s_reg.bIdx == cmt_pkg::IDX_MAILBOX)
    |=> $stable(s_reg.byteIdx))
    else $error("refused window access moved the byte index");

  chk_index_hold: assert property ( // RQ8
    (!winDone && !(regWr && s_reg.bIdx == cmt_pkg::IDX_PAGE)) |=> $stable(s_reg.byteIdx))
    else $error("byte index moved without a window access");

  chk_page_index_load: assert property ( // RQ6
    (regWr && s_reg.bIdx == cmt_pkg::IDX_PAGE) |=> s_reg.byteIdx == $past(hwdata[2:0]))
    else $error("page write did not load the byte index");

  chk_mailbox_store: assert property ( // RQ6
    memWe |=> mbox[$past(memAddr)] == $past(wByte))
    else $error("window write did not reach the mailbox");

  chk_hit_needs_valid: assert property ( // RQ1
    !cmpIn.valid |=> !acceptHit)
    else $error("match reported without a compare request");

  chk_id_mask_compare: assert property ( // RQ1
    (cmpIn.valid && !cmpIn.isTx
     && ((cmpIn.rx.id ^ cmpIn.tag.id) & s_reg.mask.id) != 29'h00000000) |=> !acceptHit)
    else $error("masked identifier mismatch accepted");

  chk_equal_match: assert property ( // RQ4
    (cmpIn.valid && cmpIn.rx == cmpIn.tag) |=> acceptHit)
    else $error("identical fields not accepted");

  // ==========================================================
  // Write paths and event captures

  chk_mask4_load: assert property ( // RQ5
    (regWr && s_reg.bIdx == cmt_pkg::IDX_MASK4)
    |=> s_reg.mask.rtr == $past(hwdata[cmt_pkg::MASK4_RTR_BIT])
        && s_reg.mask.ide == $past(hwdata[cmt_pkg::MASK4_IDE_BIT]))
    else $error("mask byte four not loaded");

  chk_mask_hold: assert property ( // RQ5
    !regWr |=> $stable(s_reg.mask))
    else $error("mask changed without a write");

  chk_prescale_load: assert property ( // RQ9
    (regWr && s_reg.bIdx == cmt_pkg::IDX_PRESCALE) |=> s_reg.prescale == $past(hwdata[7:0]))
    else $error("prescaler write lost");

  chk_prescale_hold: assert property ( // RQ9
    !regWr |=> $stable(s_reg.prescale))
    else $error("prescaler changed without a write");

  chk_timer_lo_load: assert property ( // RQ10
    (regWr && s_reg.bIdx == cmt_pkg::IDX_TIM_LO) |=> timerValue[7:0] == $past(hwdata[7:0]))
    else $error("timer low byte write lost");

  chk_timer_hi_load: assert property ( // RQ10
    (regWr && s_reg.bIdx == cmt_pkg::IDX_TIM_HI) |=> timerValue[15:8] == $past(hwdata[7:0]))
    else $error("timer high byte write lost");

  chk_stamp_hold: assert property ( // RQ11
    !frameEvent |=> $stable(s_reg.stamp))
    else $error("time stamp changed without a frame event");

  chk_ttc_capture: assert property ( // RQ12
    ttcEvent |=> s_reg.ttc == $past(timerValue))
    else $error("trigger timer missed its event");

  cov_window_wrap: cover property (winDone && s_reg.autoInc && s_reg.byteIdx == 3'd7);
  cov_rx_hit:      cover property (cmpIn.valid && !cmpIn.isTx ##1 acceptHit);
  cov_stamp:       cover property (frameEvent && preTick);
  cov_back2back:   cover property (addrTake ##2 addrTake);
  cov_refused:     cover property (s_reg.bst == cmt_pkg::BS_DATA && !s_reg.bMapped);

endmodule

// [tb/cmt_regs_test.sv]
`timescale 1ns/1ps
module cmt_regs_test;
  // ==========================================================
  // Signals
  logic                  core_clk;
  logic                  rst;
  logic                  hsel;
  logic [31:0]           haddr;
  logic [1:0]            htrans;
  logic                  hwrite;
  logic [2:0]            hsize;
  logic [31:0]           hwdata;
  logic [31:0]           hrdata;
  logic                  hreadyout;
  logic                  hresp;
  cmt_pkg::cmt_ahb_req_t ahbReq;
  cmt_pkg::cmt_cmp_t     cmpIn;
  logic                  acceptHit;
  logic                  frameEvent;
  logic                  ttcEvent;
  logic [15:0]           timerValue;
  int                    fail_count;
  int                    n_tests;
  logic [7:0]            rdQ[$];
  logic                  hitQ[$];
  logic                  rdPend = 1'b0;
  logic                  cmpPend = 1'b0;
  logic [21:0]           addrHi;

  // Compare cases: mask byte one, mask byte four, flipped bits, transmit, hit
  localparam logic [7:0]  CM1 [9] = '{8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0]  CM4 [9] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h04, 8'h01, 8'h01, 8'h00, 8'h00};
  localparam logic [30:0] CFL [9] = '{31'h40000000, 31'h40000000, 31'h20000000, 31'h4, 31'h2,
                                      31'h2, 31'h1, 31'h1, 31'h0};
  localparam logic        CTX [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  localparam logic        CEX [9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  assign ahbReq = {hsel, haddr, htrans, hwrite, hsize, hreadyout};

  cmt_regs #(.NUM_MOB(cmt_pkg::NUM_MOB_DEF)) dut (
    .core_clk   (core_clk),
    .rst        (rst),
    .ahbReq     (ahbReq),
    .hwdata     (hwdata),
    .hrdata     (hrdata),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .cmpIn      (cmpIn),
    .acceptHit  (acceptHit),
    .frameEvent (frameEvent),
    .ttcEvent   (ttcEvent),
    .timerValue (timerValue)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t bus wait ran out", $time);
      final_report();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [7:0] exp);
    if (!wr) begin
      rdQ.push_back(exp);
    end
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {addrHi, idx, 2'b00};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
  endtask

  task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 8'h00);
  endtask

  task automatic rd8(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, e);
  endtask

  task automatic cmp(input logic tx, input logic [30:0] tg, input logic [30:0] flip,
                     input logic exp);
    hitQ.push_back(exp);
    cmpIn <= {1'b1, tx, tg ^ flip, tg};
    @(posedge core_clk);
    cmpIn.valid <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // Cycles until the timer next moves, and by how much
  task automatic tick_gap(output int n, output logic [15:0] d);
    logic [15:0] a;
    a = timerValue;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (timerValue === a && n < 600);
    d = timerValue - a;
  endtask

  // ==========================================================
  // Monitor: pops the oldest note whenever a result appears
  always @(posedge core_clk) begin
    if (rdPend && hreadyout === 1'b1) begin
      check(hrdata, {24'h0, rdQ.pop_front()});
      check({31'h0, hresp}, 32'h0);
      rdPend = 1'b0;
    end
    if (hsel && htrans[1] && hreadyout && !hwrite) begin
      rdPend = 1'b1;
    end
    if (cmpPend) begin
      check({31'h0, acceptHit}, {31'h0, hitQ.pop_front()});
    end
    cmpPend = cmpIn.valid;
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [30:0] tg;
    logic [7:0]  mb [3];
    logic [3:0]  obj;
    logic [7:0]  pre;
    int          n;
    logic [15:0] d;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cmpIn = '0;
    frameEvent = 1'b0;
    ttcEvent = 1'b0;
    fail_count = 0;
    n_tests = 0;
    addrHi = 22'h0;
    void'($urandom(32'h0080));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd8(cmt_pkg::IDX_PRESCALE, 8'h00);
    rd8(cmt_pkg::IDX_TIM_HI, 8'h00);
    rd8(8'h00, 8'h00);
    wr8(cmt_pkg::IDX_MASK4, 8'hFD);
    rd8(cmt_pkg::IDX_MASK4, 8'hFD);
    mb[0] = 8'($urandom);
    wr8(cmt_pkg::IDX_MASK3, mb[0]);
    rd8(cmt_pkg::IDX_MASK3, mb[0]);
    wr8(cmt_pkg::IDX_MASK3, 8'h00);
    tg = 31'($urandom);
    for (int i = 0; i < 9; i++) begin
      wr8(cmt_pkg::IDX_MASK1, CM1[i]);
      wr8(cmt_pkg::IDX_MASK4, CM4[i]);
      cmp(CTX[i], tg, CFL[i], CEX[i]);
    end
    // Mailbox window, auto-increment across the wrap
    obj = 4'($urandom_range(14));
    for (int i = 0; i < 3; i++) begin
      mb[i] = 8'($urandom);
    end
    wr8(cmt_pkg::IDX_PAGE, {obj, 1'b1, 3'd6});
    for (int i = 0; i < 3; i++) begin
      wr8(cmt_pkg::IDX_MAILBOX, mb[i]);
    end
    wr8(cmt_pkg::IDX_PAGE, {obj, 1'b1, 3'd6});
    for (int i = 0; i < 3; i++) begin
      rd8(cmt_pkg::IDX_MAILBOX, mb[i]);
    end
    wr8(cmt_pkg::IDX_PAGE, {obj, 1'b0, 3'd0});
    rd8(cmt_pkg::IDX_MAILBOX, mb[2]);
    rd8(cmt_pkg::IDX_MAILBOX, mb[2]);
    // Out-of-range address: write dropped, read zero, index kept
    wr8(cmt_pkg::IDX_PAGE, {obj, 1'b1, 3'd0});
    addrHi = 22'h1;
    wr8(cmt_pkg::IDX_MAILBOX, ~mb[2]);
    rd8(cmt_pkg::IDX_MAILBOX, 8'h00);
    addrHi = 22'h0;
    rd8(cmt_pkg::IDX_MAILBOX, mb[2]);
    rd8(cmt_pkg::IDX_PAGE, {obj, 1'b1, 3'd1});
    // Prescaler period
    pre = 8'($urandom_range(5));
    wr8(cmt_pkg::IDX_PRESCALE, pre);
    rd8(cmt_pkg::IDX_PRESCALE, pre);
    tick_gap(n, d);
    tick_gap(n, d);
    check(n, {24'h0, pre} + 32'h1);
    check({16'h0, d}, 32'h1);
    // Slow timer, then captures on frame and trigger events
    wr8(cmt_pkg::IDX_PRESCALE, 8'hFF);
    tick_gap(n, d);
    wr8(cmt_pkg::IDX_TIM_LO, 8'h3C);
    wr8(cmt_pkg::IDX_TIM_HI, 8'hA5);
    frameEvent <= 1'b1;
    ttcEvent <= 1'b1;
    @(posedge core_clk);
    frameEvent <= 1'b0;
    ttcEvent <= 1'b0;
    wr8(cmt_pkg::IDX_TTC_LO, 8'h00);
    wr8(cmt_pkg::IDX_STMP_HI, 8'h00);
    rd8(cmt_pkg::IDX_STMP_LO, 8'h3C);
    rd8(cmt_pkg::IDX_STMP_HI, 8'hA5);
    rd8(cmt_pkg::IDX_TTC_LO, 8'h3C);
    rd8(cmt_pkg::IDX_TTC_HI, 8'hA5);
    rd8(cmt_pkg::IDX_TIM_LO, 8'h3C);
    rd8(cmt_pkg::IDX_TIM_HI, 8'hA5);
    // Reset in mid-run
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd8(cmt_pkg::IDX_PRESCALE, 8'h00);
    rd8(cmt_pkg::IDX_TIM_HI, 8'h00);
    rd8(cmt_pkg::IDX_PAGE, 8'h00);
    repeat (3) @(posedge core_clk);
    check(rdQ.size() + hitQ.size(), 32'h0);
    final_report();
  end
endmodule
